// ===== verilog/vmiw_pkg.sv
// Shared constants and types for the two-wire video matrix control port.
package vmiw_pkg;

	// Bus addresses (write form, R/W bit clear) picked by the strap
	localparam logic [7:0] DEV_ADDR_LO = 8'h06;
	localparam logic [7:0] DEV_ADDR_HI = 8'h86;

	// Output control registers sit at consecutive pointer values
	localparam logic [7:0] PTR_OUT_BASE = 8'h00;
	localparam logic [7:0] NUM_OUT      = 8'h09;
	localparam int         NUM_OUT_INT  = 9;

	// Field positions inside an output control byte
	localparam int unsigned SEL_LSB  = 0;
	localparam int unsigned GAIN_LSB = 5;
	localparam int unsigned EN_BIT   = 7;

	// Bits per byte and the acknowledge slot index
	localparam logic [3:0] BYTE_BITS = 4'h8;

	// Serial clock made by the host end
	localparam int unsigned ACLK_NS       = 40;
	localparam int unsigned SCL_PERIOD_NS = 640;
	localparam logic [3:0]  SCL_QTR_LAST  = 4'((SCL_PERIOD_NS / (4 * ACLK_NS)) - 1);

	// Host register offsets (byte addresses)
	localparam logic [3:0] REG_CFG  = 4'h0;
	localparam logic [3:0] REG_GO   = 4'h4;
	localparam logic [3:0] REG_STAT = 4'h8;

	// Host register fields
	localparam int unsigned CFG_ADDR_LSB = 0;
	localparam int unsigned CFG_PTR_LSB  = 8;
	localparam int unsigned CFG_DATA_LSB = 16;
	localparam int unsigned CFG_RD_BIT   = 24;
	localparam int unsigned CFG_RD2_BIT  = 25;
	localparam int unsigned GO_BIT       = 0;
	localparam int unsigned STAT_BUSY    = 0;
	localparam int unsigned STAT_NACK    = 1;
	localparam int unsigned STAT_RD_LSB  = 8;

	// Reset values
	localparam logic [31:0] CFG_RST  = 32'h0000_0006;
	localparam logic [7:0]  CTRL_RST = 8'h00;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// One output control byte: enable, gain, input select
	typedef struct packed {
		logic       en;
		logic [1:0] gain;
		logic [4:0] sel;
	} vmiw_ctrl_t;

endpackage

// ===== verilog/vmiw_link_if.sv
// Two-wire link between the host end and the device end.
`timescale 1ns/1ps
interface vmiw_link_if;
	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic s_sda_o;
	logic s_sda_oe;
	logic scl;
	logic sda;

	// Open-drain wired-and; released lines float high
	assign scl = m_scl_oe ? m_scl_o : 1'b1;
	assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);

	modport dev (input scl, input sda, output s_sda_o, output s_sda_oe);
	modport host (input sda, output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe);
endinterface

// ===== verilog/vmiw_sync.sv
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module vmiw_sync #(
	parameter int W = 1
) (
	// System
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	// First stage feeds only the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta <= '1;
			q    <= '1;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

// ===== verilog/vmiw_dev.sv
// Device end: two-wire slave port writing the output control registers.
// Behaviour
// - Any number of bytes per transfer
// - Eight data bits then one acknowledge slot
// - Master clocks one extra acknowledge pulse
// - Device acknowledges every byte it receives except a foreign address
// - Master acknowledges bytes it reads
// - Acknowledger holds data low through pulse
// - Master ends read by withholding acknowledge
// - Device releases data line on missing acknowledge
// - First byte after start is address
// - Pointer byte first, then register data
// - Address 0x06 strap low, 0x86 high
// - Undefined pointers accepted, acknowledged, ignored
// - Select 4:0, gain, enable; reset zero
// - Disable powers down and deselects input
`timescale 1ns/1ps
module vmiw_dev (
	// System
	input  wire logic                                        aclk,
	input  wire logic                                        aresetn,
	// Address strap
	input  wire logic                                        addr_sel,
	// Two-wire link
	vmiw_link_if.dev                                         link,
	// Output controls
	output vmiw_pkg::vmiw_ctrl_t [vmiw_pkg::NUM_OUT_INT-1:0] out_ctrl
);
	import vmiw_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_RX_ACK,
		ST_TX,
		ST_TX_ACK
	} vmiw_dstate_t;

	typedef enum logic [1:0] {
		K_ADDR,
		K_PTR,
		K_DATA
	} vmiw_kind_t;

	vmiw_dstate_t state;
	vmiw_kind_t   kind;
	logic [2:0]   pin_s;
	logic         scl_q;
	logic         sda_q;
	logic         scl_rise;
	logic         scl_fall;
	logic         start_det;
	logic         stop_det;
	logic [3:0]   bit_cnt;
	logic [7:0]   shreg;
	logic [7:0]   tx;
	logic [7:0]   ptr;
	logic [7:0]   my_addr;
	logic [7:0]   cur_byte;
	logic         sda_oe;
	logic         wr_commit;
	vmiw_ctrl_t   next_ctrl;

	// Pointer lands on an output control register
	function automatic logic is_out(input logic [7:0] p);
		return (p >= PTR_OUT_BASE) && (p < PTR_OUT_BASE + NUM_OUT);
	endfunction

	// Array index for a pointer already known to hit
	function automatic logic [3:0] out_idx(input logic [7:0] p);
		logic [7:0] off;
		off = p - PTR_OUT_BASE;
		return off[3:0];
	endfunction

	// Strap, clock and data all come from outside this domain
	vmiw_sync #(
		.W(3)
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({addr_sel, link.scl, link.sda}),
		.q       (pin_s)
	);

	// Previous synced levels for edge and condition detection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= pin_s[1];
			sda_q <= pin_s[0];
		end
	end

	// Start and stop are data edges while the clock is high
	assign scl_rise  = pin_s[1] & ~scl_q;
	assign scl_fall  = ~pin_s[1] & scl_q;
	assign start_det = pin_s[1] & scl_q & sda_q & ~pin_s[0];
	assign stop_det  = pin_s[1] & scl_q & ~sda_q & pin_s[0];

	// Strap picks one of two bus addresses
	assign my_addr = pin_s[2] ? DEV_ADDR_HI : DEV_ADDR_LO;

	// Read-back value; undefined pointers read zero
	assign cur_byte = is_out(ptr) ? out_ctrl[out_idx(ptr)] : 8'h00;

	// Open drain: only ever pull low
	assign link.s_sda_o  = 1'b0;
	assign link.s_sda_oe = sda_oe;

	// Byte engine; start and stop override any state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state   <= ST_IDLE;
			kind    <= K_ADDR;
			bit_cnt <= 4'h0;
			shreg   <= 8'h00;
			tx      <= 8'h00;
			ptr     <= 8'h00;
			sda_oe  <= 1'b0;
		end else if (start_det) begin
			state   <= ST_RX;
			kind    <= K_ADDR;
			bit_cnt <= 4'h0;
			sda_oe  <= 1'b0;
		end else if (stop_det) begin
			state  <= ST_IDLE;
			sda_oe <= 1'b0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					sda_oe <= 1'b0;
				end
				ST_RX: begin
					if (scl_rise) begin
						shreg   <= {shreg[6:0], pin_s[0]};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == BYTE_BITS) begin
						// Foreign address: stay off the bus
						if (kind == K_ADDR && shreg[7:1] != my_addr[7:1]) begin
							state <= ST_IDLE;
						end else begin
							sda_oe <= 1'b1;
							state  <= ST_RX_ACK;
						end
					end
				end
				ST_RX_ACK: begin
					// Hold low until the acknowledge pulse ends
					if (scl_fall) begin
						sda_oe  <= 1'b0;
						bit_cnt <= 4'h0;
						state   <= ST_RX;
						unique case (kind)
							K_ADDR: begin
								if (shreg[0]) begin
									tx     <= cur_byte;
									sda_oe <= ~cur_byte[7];
									state  <= ST_TX;
								end else begin
									kind <= K_PTR;
								end
							end
							K_PTR: begin
								ptr  <= shreg;
								kind <= K_DATA;
							end
							default: begin
								ptr <= ptr + 8'h01;
							end
						endcase
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall) begin
						if (bit_cnt == BYTE_BITS) begin
							sda_oe <= 1'b0;
							state  <= ST_TX_ACK;
						end else begin
							tx     <= {tx[6:0], 1'b0};
							sda_oe <= ~tx[6];
						end
					end
				end
				ST_TX_ACK: begin
					if (scl_rise) begin
						// Missing acknowledge: leave the line released
						if (pin_s[0]) begin
							state <= ST_IDLE;
						end else begin
							ptr <= ptr + 8'h01;
						end
					end else if (scl_fall) begin
						tx      <= cur_byte;
						sda_oe  <= ~cur_byte[7];
						bit_cnt <= 4'h0;
						state   <= ST_TX;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Commit only at the close of the acknowledge pulse
	assign wr_commit = (state == ST_RX_ACK) && scl_fall && (kind == K_DATA)
		&& !start_det && !stop_det;

	// Disabling an output also drops its input selection
	always_comb begin
		next_ctrl = vmiw_ctrl_t'(shreg);
		if (!next_ctrl.en) begin
			next_ctrl.sel = '0;
		end
	end

	// One register per output; other pointers change nothing
	for (genvar i = 0; i < NUM_OUT_INT; i++) begin : g_out
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				out_ctrl[i] <= vmiw_ctrl_t'(CTRL_RST);
			end else if (wr_commit && is_out(ptr) && out_idx(ptr) == 4'(i)) begin
				out_ctrl[i] <= next_ctrl;
			end
		end
	end
endmodule

// ===== verilog/vmiw_host.sv
// Host end: AXI4-Lite controlled two-wire bus master.
`timescale 1ns/1ps
module vmiw_host (
	// System
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write
	input  wire logic [3:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic [3:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Two-wire link
	vmiw_link_if.host        link
);
	import vmiw_pkg::*;

	typedef enum logic [1:0] {
		H_IDLE,
		H_START,
		H_BIT,
		H_STOP
	} vmiw_hstate_t;

	vmiw_hstate_t state;
	logic [31:0]  cfg;
	logic [3:0]   aw_addr;
	logic [31:0]  w_data;
	logic [3:0]   w_strb;
	logic         aw_got;
	logic         w_got;
	logic         do_wr;
	logic         busy;
	logic         nack;
	logic [15:0]  rd_bytes;
	logic [3:0]   tick;
	logic [1:0]   qtr;
	logic         step;
	logic [3:0]   bit_idx;
	logic [1:0]   byte_idx;
	logic [1:0]   last_idx;
	logic         rd_op;
	logic         receiving;
	logic         last_byte;
	logic [7:0]   tx_byte;
	logic         drive_low;
	logic         sda_s;
	logic         scl_oe;
	logic         sda_oe;

	assign busy = (state != H_IDLE);

	// AXI channels; both write halves taken in either order
	assign awready = ~aw_got & ~bvalid;
	assign wready  = ~w_got & ~bvalid;
	assign arready = ~rvalid;
	assign do_wr   = aw_got & w_got & ~bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got  <= 1'b0;
			w_got   <= 1'b0;
			aw_addr <= 4'h0;
			w_data  <= 32'h0;
			w_strb  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_got  <= 1'b1;
				aw_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_got  <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (do_wr) begin
				aw_got <= 1'b0;
				w_got  <= 1'b0;
				bvalid <= 1'b1;
				bresp  <= (aw_addr == REG_CFG || aw_addr == REG_GO) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Config bytes follow the strobes; frozen while a transfer runs
	for (genvar b = 0; b < 4; b++) begin : g_cfg
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				cfg[8*b +: 8] <= CFG_RST[8*b +: 8];
			end else if (do_wr && aw_addr == REG_CFG && w_strb[b] && !busy) begin
				cfg[8*b +: 8] <= w_data[8*b +: 8];
			end
		end
	end

	// Read data path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0;
			rresp  <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp  <= RESP_OKAY;
			unique case (araddr)
				REG_CFG:  rdata <= cfg;
				REG_GO:   rdata <= 32'h0;
				REG_STAT: rdata <= {8'h00, rd_bytes, 6'h00, nack, busy};
				default: begin
					rdata <= 32'h0;
					rresp <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	// Data line comes back from the wire
	vmiw_sync #(
		.W(1)
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (link.sda),
		.q       (sda_s)
	);

	// Quarter-period timebase for the serial clock
	assign step = (tick == SCL_QTR_LAST);

	always_ff @(posedge aclk) begin
		if (!aresetn || !busy) begin
			tick <= 4'h0;
			qtr  <= 2'h0;
		end else begin
			tick <= step ? 4'h0 : tick + 4'h1;
			if (step) begin
				qtr <= qtr + 2'h1;
			end
		end
	end

	// Byte plan: address, then pointer and data, or one or two reads
	assign rd_op     = cfg[CFG_RD_BIT];
	assign last_idx  = rd_op ? (cfg[CFG_RD2_BIT] ? 2'h2 : 2'h1) : 2'h2;
	assign receiving = rd_op && (byte_idx != 2'h0);
	assign last_byte = (byte_idx == last_idx);
	assign tx_byte   = (byte_idx == 2'h0) ? {cfg[CFG_ADDR_LSB+1 +: 7], rd_op} :
		(byte_idx == 2'h1) ? cfg[CFG_PTR_LSB +: 8] : cfg[CFG_DATA_LSB +: 8];

	// Ack slot: acknowledge reads except the last, else release
	always_comb begin
		if (bit_idx < BYTE_BITS) begin
			drive_low = !receiving && !tx_byte[3'(4'h7 - bit_idx)];
		end else begin
			drive_low = receiving && !last_byte;
		end
	end

	assign link.m_scl_o  = 1'b0;
	assign link.m_sda_o  = 1'b0;
	assign link.m_scl_oe = scl_oe;
	assign link.m_sda_oe = sda_oe;

	// Bit sequencer: data set mid-low, sampled mid-high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state    <= H_IDLE;
			scl_oe   <= 1'b0;
			sda_oe   <= 1'b0;
			bit_idx  <= 4'h0;
			byte_idx <= 2'h0;
			nack     <= 1'b0;
			rd_bytes <= 16'h0;
		end else begin
			unique case (state)
				H_IDLE: begin
					if (do_wr && aw_addr == REG_GO && w_strb[0] && w_data[GO_BIT]) begin
						state    <= H_START;
						nack     <= 1'b0;
						bit_idx  <= 4'h0;
						byte_idx <= 2'h0;
					end
				end
				H_START: begin
					if (step && qtr == 2'h1) begin
						sda_oe <= 1'b1;
					end else if (step && qtr == 2'h3) begin
						scl_oe <= 1'b1;
						state  <= H_BIT;
					end
				end
				H_BIT: begin
					if (step) begin
						unique case (qtr)
							2'h0: sda_oe <= drive_low;
							2'h1: scl_oe <= 1'b0;
							2'h2: begin
								if (bit_idx < BYTE_BITS && receiving) begin
									rd_bytes <= {rd_bytes[14:0], sda_s};
								end else if (bit_idx == BYTE_BITS && !receiving && sda_s) begin
									nack <= 1'b1;
								end
							end
							2'h3: begin
								// Ninth pulse closes each byte
								scl_oe <= 1'b1;
								if (bit_idx == BYTE_BITS) begin
									bit_idx  <= 4'h0;
									byte_idx <= byte_idx + 2'h1;
									if (last_byte || nack) begin
										state <= H_STOP;
									end
								end else begin
									bit_idx <= bit_idx + 4'h1;
								end
							end
						endcase
					end
				end
				H_STOP: begin
					if (step) begin
						unique case (qtr)
							2'h0: sda_oe <= 1'b1;
							2'h1: scl_oe <= 1'b0;
							2'h2: sda_oe <= 1'b0;
							2'h3: state <= H_IDLE;
						endcase
					end
				end
			endcase
		end
	end
endmodule

// ===== sim/vmiw_properties.sv
// Link checker watching the two-wire lines between host and device ends.
`timescale 1ns/1ps
module vmiw_properties (
	// System
	input wire logic aclk,
	input wire logic aresetn,
	// Link
	input wire logic scl,
	input wire logic sda,
	input wire logic s_sda_oe
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic       scl_q;
	logic       sda_q;
	logic       first;
	logic       in_read;
	logic       acked;
	logic       ignored;
	logic [3:0] bitcnt;
	wire        start = scl && scl_q && sda_q && !sda;
	wire        stop  = scl && scl_q && !sda_q && sda;
	wire        rise  = scl && !scl_q;

	// Line history for edge and framing detection
	always_ff @(posedge aclk) begin
		scl_q <= aresetn ? scl : 1'b1;
		sda_q <= aresetn ? sda : 1'b1;
	end

	// Pulse count in the byte; the stop release also counts as a rise
	always_ff @(posedge aclk) begin
		if (!aresetn || start) begin
			bitcnt <= 4'h0;
		end else if (rise) begin
			bitcnt <= (bitcnt == 4'h8) ? 4'h0 : bitcnt + 4'h1;
		end
	end

	// Outcome of the address byte, held until the next start
	always_ff @(posedge aclk) begin
		if (!aresetn || start) begin
			first   <= 1'b1;
			in_read <= 1'b0;
			acked   <= 1'b0;
			ignored <= 1'b0;
		end else if (rise && first) begin
			if (bitcnt == 4'h7) in_read <= sda;
			if (bitcnt == 4'h8) begin
				first   <= 1'b0;
				acked   <= s_sda_oe;
				ignored <= !s_sda_oe;
			end
		end
	end

	// Acknowledge held low through the high phase
	sequence ack_held_s;
		(s_sda_oe && !sda) [*7];
	endsequence
	sequence scl_low_s;
		!scl [*6];
	endsequence

	ack_hold_a: assert property (rise && s_sda_oe |-> ack_held_s)
		else $error("acknowledge not held low while clock high");
	dev_edge_low_a: assert property ($changed(s_sda_oe) |-> !scl && !scl_q)
		else $error("device changed data line while clock high");
	ack_slot_only_a: assert property (rise && s_sda_oe && !in_read |-> bitcnt == 4'h8)
		else $error("device pulled data outside the acknowledge slot");
	ack_every_byte_a: assert property (rise && bitcnt == 4'h8 && !first && acked && !in_read
		|-> s_sda_oe)
		else $error("device missed an acknowledge");
	ignore_foreign_a: assert property (ignored |-> !s_sda_oe)
		else $error("device drove line after foreign address");
	tx_free_a: assert property (rise && bitcnt == 4'h8 && in_read && !first |-> !s_sda_oe)
		else $error("device drove the acknowledge slot of a read");
	whole_bytes_a: assert property (stop |-> bitcnt == 4'h1)
		else $error("stop not after a whole byte and acknowledge");
	start_hold_a: assert property (start |-> scl [*6])
		else $error("clock pulled too soon after start");
	scl_low_a: assert property ($fell(scl) |-> scl_low_s)
		else $error("clock low phase too short");
endmodule

// ===== sim/testbench.sv
// Bench: AXI-driven host end writes the device end over the link.
`timescale 1ns/1ps
module testbench;
	import vmiw_pkg::*;
	logic                         aclk;
	logic                         aresetn;
	logic                         addr_sel;
	logic [3:0]                   awaddr;
	logic                         awvalid;
	logic                         awready;
	logic [31:0]                  wdata;
	logic [3:0]                   wstrb;
	logic                         wvalid;
	logic                         wready;
	logic [1:0]                   bresp;
	logic                         bvalid;
	logic                         bready;
	logic [3:0]                   araddr;
	logic                         arvalid;
	logic                         arready;
	logic [31:0]                  rdata;
	logic [1:0]                   rresp;
	logic                         rvalid;
	logic                         rready;
	vmiw_ctrl_t [NUM_OUT_INT-1:0] out_ctrl;
	logic [7:0]                   exp_ctrl [NUM_OUT_INT];
	int                           n_mismatch;
	int                           tests_run;
	int                           cyc;

	vmiw_link_if link ();
	vmiw_host u_vmiw_host (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.link(link));
	vmiw_dev u_vmiw_dev (.aclk(aclk), .aresetn(aresetn), .addr_sel(addr_sel), .link(link),
		.out_ctrl(out_ctrl));
	vmiw_properties u_vmiw_properties (.aclk(aclk), .aresetn(aresetn), .scl(link.scl),
		.sda(link.sda), .s_sda_oe(link.s_sda_oe));

	// Clock
	always #20 aclk = ~aclk;

	// Hang guard, well above the expected run length
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 30000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// Handshakes sampled at the falling edge: same values as the next rising edge, no race
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
		logic aw_hit;
		logic w_hit;
		logic b_hit;
		b_hit = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b_hit) begin
			@(negedge aclk);
			aw_hit = awvalid && awready;
			w_hit = wvalid && wready;
			b_hit = bvalid && bready;
			resp = bresp;
			@(posedge aclk);
			if (aw_hit) awvalid <= 1'b0;
			if (w_hit) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
		logic ar_hit;
		logic r_hit;
		r_hit = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r_hit) begin
			@(negedge aclk);
			ar_hit = arvalid && arready;
			r_hit = rvalid && rready;
			d = rdata;
			resp = rresp;
			@(posedge aclk);
			if (ar_hit) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask

	// Load the config word, start the link, poll until the host is idle
	task automatic run_cfg(input logic [31:0] c, output logic [31:0] r);
		logic [1:0] s;
		axi_write(REG_CFG, c, s);
		axi_write(REG_GO, 32'h0000_0001, s);
		r = 32'h0000_0001;
		while (r[STAT_BUSY] !== 1'b0) axi_read(REG_STAT, r, s);
	endtask

	// One link write of address, pointer and data, then outcome and outputs
	task automatic xfer(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d,
		input logic nack);
		logic [31:0] r;
		run_cfg({8'h00, d, p, a}, r);
		check("nack", {31'h0, r[STAT_NACK]}, {31'h0, nack});
		for (int i = 0; i < NUM_OUT_INT; i++) begin
			check("out_ctrl", {24'h0, out_ctrl[i]}, {24'h0, exp_ctrl[i]});
		end
	endtask

	initial begin
		logic [31:0] r;
		logic [1:0]  s;
		{aclk, aresetn, addr_sel, awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready, n_mismatch, tests_run, cyc} = '0;
		wstrb = 4'hf;
		foreach (exp_ctrl[i]) exp_ctrl[i] = CTRL_RST;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		for (int i = 0; i < NUM_OUT_INT; i++) check("rst", {24'h0, out_ctrl[i]}, 32'h0);
		axi_read(REG_CFG, r, s);
		check("cfg", r, CFG_RST);
		axi_read(4'hc, r, s);
		check("rresp", {30'h0, s}, {30'h0, RESP_SLVERR});
		axi_write(4'hc, 32'h0, s);
		check("bresp", {30'h0, s}, {30'h0, RESP_SLVERR});
		// Every output register with its own select; gain cycles 0 to 3
		for (int i = 0; i < NUM_OUT_INT; i++) begin
			exp_ctrl[i] = {1'b1, 2'(i), 5'(i + 1)};
			xfer(DEV_ADDR_LO, 8'(i), exp_ctrl[i], 1'b0);
		end
		// Disable drops the input select, gain kept
		exp_ctrl[2] = 8'h60;
		xfer(DEV_ADDR_LO, 8'h02, 8'h7f, 1'b0);
		xfer(DEV_ADDR_LO, 8'h40, 8'hff, 1'b0);
		xfer(DEV_ADDR_HI, 8'h00, 8'h00, 1'b1);
		// Strap high moves the bus address
		addr_sel <= 1'b1;
		repeat (4) @(posedge aclk);
		xfer(DEV_ADDR_LO, 8'h01, 8'h00, 1'b1);
		exp_ctrl[8] = 8'h9f;
		xfer(DEV_ADDR_HI, 8'h08, 8'h9f, 1'b0);
		// Two-byte read from the pointer left by a write; host refuses the last
		xfer(DEV_ADDR_HI, 8'h06, exp_ctrl[6], 1'b0);
		run_cfg({6'h00, 1'b1, 1'b1, 16'h0000, DEV_ADDR_HI}, r);
		check("rd", {16'h0, r[STAT_RD_LSB +: 16]}, {16'h0, exp_ctrl[7], exp_ctrl[8]});
		check("rd_nack", {31'h0, r[STAT_NACK]}, 32'h0);
		// Device must have let go of the line after the refused byte
		exp_ctrl[0] = 8'h00;
		xfer(DEV_ADDR_HI, 8'h00, 8'h00, 1'b0);
		report_and_stop();
	end
endmodule
